// >>> design/mcmd_core.sv
// Behaviour
// (RL1) Reset command or pin zeroes filter, trajectory, their buffers and motor output.
// (RL2) Zero motor output is 80 hex narrow, 800 hex wide.
// (RL3) During reset port shows 800 hex, then reverts to 80 hex.
// (RL4) Reset masks breakpoint interrupt and unmasks the other five.
// (RL5) Reset selects narrow output and takes current position as home.
// (RL6) Reset accepted anytime, finishes within 1.5 ms; the code takes command 00 only when idle, and the pin at any time.
// (RL7) Command 05 selects narrow latched output, also the default.
// (RL8) Host never selects narrow output with a wide converter.
// (RL9) Host selects wide output with 06 early and after each reset.
// (RL10) Host never selects wide output with narrow or pulse-width output.
// (RL11) Command 02 makes current position absolute zero.
// (RL12) Home redefinition keeps current stop position until start motion.
// (RL13) Interrupt output asserted only for unmasked conditions.
// (RL14) Status flags follow conditions regardless of mask.
// (RL15) Command 03 captures position at next index, sets status bit 3.
// (RL16) Capture when both phases and index are low.
// (RL17) Command 1B loads two-byte error threshold, high byte first.
// (RL18) Error magnitude above threshold sets status bit 5.
// (RL19) Command 1A also forces motor output to zero code on error.
// (RL20) Command 20 loads four-byte absolute breakpoint; reaching sets bit 6.
// (RL21) Command 21 loads breakpoint relative to target position.
// (RL22) Host keeps relative breakpoint plus target within position range.
// (RL23) Command byte written with port select low after busy found low.
// (RL24) Command written while busy is ignored.
// (RL25) Data goes as big-endian word pairs, busy checked per word.
// (RL26) Mask command uses bits 1 to 6 of low byte, zero masks.
// (RL27) Breakpoint compared each sample, flag set when reached or passed.
`timescale 1ns/1ps
module mcmd_core
  import mcmd_pkg::*;
(
  input  wire logic               clk_sys,       // System clock
  input  wire logic               rst_n,         // Hardware reset
  input  wire mcmd_hostwr_t       hostWr,        // Host write strobe and byte
  input  wire mcmd_loop_t         loopIn,        // Loop and encoder state
  input  wire logic [6:1]         condIn,        // Other condition levels from the loop
  output logic [7:0]              statusByte,    // Status byte
  output logic                    hostIrq,       // Host interrupt
  output logic [11:0]             motorOut,      // Converter port value
  output logic                    wideMode,      // Wide output selected
  output logic                    clearLoop,     // Zero filter and trajectory state
  output logic                    startHold,     // Home moved: stop point kept until start
  output logic signed [31:0]      homeOffset,    // Position of home
  output logic signed [31:0]      indexPos,      // Captured index position
  output logic [6:1]              intMask        // Interrupt enables
);

  mcmd_state_t        state_q;
  logic [CNT_W-1:0]   cnt_q;
  logic [7:0]         cmd_q;
  logic [2:0]         words_q;
  logic               hiPhase_q;
  logic [7:0]         hiByte_q;
  logic [15:0]        word0_q;
  logic [15:0]        errThresh_q;
  logic               errStop_q;
  logic signed [31:0] bkpt_q;
  logic               bkptArm_q;
  logic               bkptAbove_q;
  logic               indexArm_q;
  logic [6:1]         flag_q;
  logic               prevWr_q;
  logic               wrRise;
  logic               cmdTake;
  logic               dataTake;
  logic               softReset;
  logic signed [31:0] relPos;
  logic [15:0]        errMag;
  logic               bkptHit;
  logic               idxHit;

  function automatic logic [2:0] wordsFor(input logic [7:0] c);
    unique case (c)
      CMD_ERR_STOP, CMD_ERR_REPORT, CMD_MASK, CMD_FLAG_CLR: wordsFor = WORDS_TWO;
      CMD_BP_ABS, CMD_BP_REL:                               wordsFor = WORDS_FOUR;
      default:                                              wordsFor = 3'h0;
    endcase
  endfunction

  assign wrRise    = hostWr.wrStrobe & ~prevWr_q;
  assign cmdTake   = wrRise & ~hostWr.portSelN & (state_q == ST_IDLE); // RL23 RL24
  assign dataTake  = wrRise & hostWr.portSelN & (state_q == ST_DATA); // RL25
  assign softReset = cmdTake & (hostWr.data == CMD_RESET); // RL6
  assign relPos    = loopIn.actualPos - homeOffset;
  assign errMag    = loopIn.posError[15] ? 16'(-loopIn.posError) : 16'(loopIn.posError);
  assign bkptHit   = bkptArm_q & loopIn.sampleTick
                     & (bkptAbove_q ? (relPos <= bkpt_q) : (relPos >= bkpt_q)); // RL27
  assign idxHit    = indexArm_q & ~loopIn.phaseA & ~loopIn.phaseB & ~loopIn.indexIn; // RL16

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prevWr_q <= 1'b0;
    end else begin
      prevWr_q <= hostWr.wrStrobe;
    end
  end

  // Command sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q   <= ST_RESET;
      cnt_q     <= CNT_W'(RESET_CYC);
      cmd_q     <= 8'h00;
      words_q   <= 3'h0;
      hiPhase_q <= 1'b1;
      hiByte_q  <= 8'h00;
      word0_q   <= 16'h0000;
    end else if (softReset) begin
      state_q <= ST_RESET; // RL1
      cnt_q   <= CNT_W'(RESET_CYC);
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (cmdTake) begin
            cmd_q     <= hostWr.data;
            words_q   <= wordsFor(hostWr.data);
            hiPhase_q <= 1'b1;
            cnt_q     <= CNT_W'(BUSY_CYC);
            state_q   <= ST_BUSY;
          end
        end
        ST_RESET: begin
          if (cnt_q == '0) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ST_DATA: begin
          if (dataTake && hiPhase_q) begin
            hiByte_q  <= hostWr.data;
            hiPhase_q <= 1'b0;
          end else if (dataTake) begin
            word0_q   <= {hiByte_q, hostWr.data};
            hiPhase_q <= 1'b1;
            words_q   <= words_q - 1'b1;
            cnt_q     <= CNT_W'(BUSY_CYC);
            state_q   <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else if (words_q != 3'h0) begin
            state_q <= ST_DATA;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // A word completes when busy starts with one fewer outstanding
  logic wordDone;
  logic lastWord;
  assign wordDone = dataTake & ~hiPhase_q;
  assign lastWord = wordDone & (words_q == 3'h1);

  // Configuration and registers loaded by commands
  always_ff @(posedge clk_sys) begin
    if (!rst_n || softReset) begin
      wideMode   <= 1'b0; // RL5
      intMask    <= MASK_RESET; // RL4
      errThresh_q <= 16'h7FFF;
      errStop_q  <= 1'b0;
      bkpt_q     <= '0;
      bkptArm_q  <= 1'b0;
      bkptAbove_q <= 1'b0;
      startHold  <= 1'b0;
    end else begin
      if (cmdTake && hostWr.data == CMD_NARROW) begin
        wideMode <= 1'b0; // RL7
      end
      if (cmdTake && hostWr.data == CMD_WIDE) begin
        wideMode <= 1'b1;
      end
      if (cmdTake && hostWr.data == CMD_DEF_HOME && state_q == ST_IDLE) begin
        startHold <= 1'b1; // RL12
      end else if (cmdTake && hostWr.data == CMD_START) begin
        startHold <= 1'b0;
      end
      if (lastWord) begin
        unique case (cmd_q)
          CMD_ERR_REPORT: begin
            errThresh_q <= {1'b0, hiByte_q[6:0], hostWr.data}; // RL17
            errStop_q   <= 1'b0;
          end
          CMD_ERR_STOP: begin
            errThresh_q <= {1'b0, hiByte_q[6:0], hostWr.data}; // RL19
            errStop_q   <= 1'b1;
          end
          CMD_MASK: intMask <= hostWr.data[6:1]; // RL26
          CMD_BP_ABS, CMD_BP_REL: begin
            bkpt_q <= (cmd_q == CMD_BP_REL)
                      ? loopIn.targetPos - homeOffset + $signed({word0_q, hiByte_q, hostWr.data})
                      : $signed({word0_q, hiByte_q, hostWr.data}); // RL20 RL21
            bkptArm_q   <= 1'b1;
            bkptAbove_q <= relPos > ((cmd_q == CMD_BP_REL)
                      ? loopIn.targetPos - homeOffset + $signed({word0_q, hiByte_q, hostWr.data})
                      : $signed({word0_q, hiByte_q, hostWr.data}));
          end
          default: ;
        endcase
      end else if (bkptHit) begin
        bkptArm_q <= 1'b0;
      end
    end
  end

  // Home and index capture
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      homeOffset <= '0;
      indexPos   <= '0;
      indexArm_q <= 1'b0;
    end else begin
      if (softReset || (state_q == ST_RESET && cnt_q == '0)) begin
        homeOffset <= loopIn.actualPos; // RL5
      end else if (cmdTake && hostWr.data == CMD_DEF_HOME) begin
        homeOffset <= loopIn.actualPos; // RL11
      end
      if (softReset) begin
        indexArm_q <= 1'b0;
      end else if (cmdTake && hostWr.data == CMD_ARM_INDEX) begin
        indexArm_q <= 1'b1; // RL15
      end else if (idxHit) begin
        indexPos   <= relPos; // RL15
        indexArm_q <= 1'b0;
      end
    end
  end

  // Condition flags: set wins over clear
  logic [6:1] setEv;
  logic [6:1] clrEv;
  always_comb begin
    setEv           = condIn & COND_EXT;
    setEv[BIT_INDEX] = idxHit;
    setEv[BIT_PERR]  = errMag > errThresh_q; // RL18
    setEv[BIT_BKPT]  = bkptHit;
    clrEv = (lastWord && cmd_q == CMD_FLAG_CLR) ? ~hostWr.data[6:1] : 6'h00;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || softReset) begin
      flag_q <= 6'h00;
    end else begin
      flag_q <= (flag_q & ~clrEv) | setEv; // RL14
    end
  end

  // Motor output
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      motorOut <= ZERO_WIDE; // RL3
    end else if (softReset || state_q == ST_RESET) begin
      // A soft reset comes from idle, where the counter already rests at zero
      motorOut <= (!softReset && cnt_q == '0) ? ZERO_NARROW : ZERO_WIDE; // RL1 RL3
    end else if (errStop_q && flag_q[BIT_PERR]) begin
      motorOut <= wideMode ? ZERO_WIDE : ZERO_NARROW; // RL2 RL19
    end else if (wideMode) begin
      motorOut <= loopIn.filterOut;
    end else begin
      motorOut <= {4'h0, loopIn.filterOut[11:4]};
    end
  end

  assign clearLoop  = (state_q == ST_RESET); // RL1
  assign hostIrq    = |(flag_q & intMask); // RL13
  assign statusByte = {1'b0, flag_q, state_q != ST_IDLE && state_q != ST_DATA};

endmodule

// >>> design/mcmd_pkg.sv
package mcmd_pkg;

  localparam logic [7:0] CMD_RESET      = 8'h00;
  localparam logic [7:0] CMD_START      = 8'h01;
  localparam logic [7:0] CMD_DEF_HOME   = 8'h02;
  localparam logic [7:0] CMD_ARM_INDEX  = 8'h03;
  localparam logic [7:0] CMD_NARROW     = 8'h05;
  localparam logic [7:0] CMD_WIDE       = 8'h06;
  localparam logic [7:0] CMD_ERR_STOP   = 8'h1A;
  localparam logic [7:0] CMD_ERR_REPORT = 8'h1B;
  localparam logic [7:0] CMD_MASK       = 8'h1C;
  localparam logic [7:0] CMD_FLAG_CLR   = 8'h1D;
  localparam logic [7:0] CMD_BP_ABS     = 8'h20;
  localparam logic [7:0] CMD_BP_REL     = 8'h21;

  localparam int BIT_BUSY  = 0;
  localparam int BIT_INDEX = 3;
  localparam int BIT_PERR  = 5;
  localparam int BIT_BKPT  = 6;

  localparam logic [11:0] ZERO_WIDE   = 12'h800;
  localparam logic [11:0] ZERO_NARROW = 12'h080;
  localparam logic [6:1]  MASK_RESET  = 6'h1F;
  // Conditions that arrive from outside: command error, trajectory done, wrap-around
  localparam logic [6:1]  COND_EXT    = 6'h0B;

  localparam int CLK_MHZ         = 125;
  localparam int RESET_US_X10    = 15;
  localparam int RESET_LIMIT_CYC = RESET_US_X10 * 100 * CLK_MHZ;
  // Reset window kept well inside the limit; its exact length is free
  localparam int RESET_CYC       = 4095;
  localparam int BUSY_CYC     = 16;
  localparam int CNT_W        = 18;

  localparam logic [2:0] WORDS_TWO  = 3'h1;
  localparam logic [2:0] WORDS_FOUR = 3'h2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RESET = 3'b001,
    ST_DATA  = 3'b010,
    ST_BUSY  = 3'b011
  } mcmd_state_t;

  typedef struct packed {
    logic        portSelN;
    logic        wrStrobe;
    logic [7:0]  data;
  } mcmd_hostwr_t;

  typedef struct packed {
    logic signed [31:0] actualPos;
    logic signed [31:0] targetPos;
    logic signed [15:0] posError;
    logic [11:0]        filterOut;
    logic               phaseA;
    logic               phaseB;
    logic               indexIn;
    logic               sampleTick;
  } mcmd_loop_t;

endpackage

// >>> testbench/mcmd_core_sva.sv
`timescale 1ns/1ps
module mcmd_core_sva
  import mcmd_pkg::*;
(
  input wire logic               clk_sys,    // Clock
  input wire logic               rst_n,      // Reset
  input wire mcmd_hostwr_t       hostWr,     // Host write
  input wire mcmd_loop_t         loopIn,     // Loop state
  input wire logic [6:1]         condIn,     // Conditions
  input wire logic [7:0]         statusByte, // Status
  input wire logic               hostIrq,    // Interrupt
  input wire logic [11:0]        motorOut,   // Converter port
  input wire logic               wideMode,   // Wide output
  input wire logic               clearLoop,  // Reset window
  input wire logic               startHold,  // Home hold
  input wire logic signed [31:0] homeOffset, // Home
  input wire logic signed [31:0] indexPos,   // Index capture
  input wire logic [6:1]         intMask     // Enables
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [CNT_W-1:0] rstLen_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !clearLoop) begin
      rstLen_q <= '0;
    end else begin
      rstLen_q <= rstLen_q + 1'b1;
    end
  end
  property p_rlen; rstLen_q <= CNT_W'(RESET_LIMIT_CYC); endproperty
  a_rlen: assert property (p_rlen) else $error("reset window too long");
  wire cmdTake = hostWr.wrStrobe && !hostWr.portSelN && !statusByte[BIT_BUSY];
  wire idxLow  = !loopIn.phaseA && !loopIn.phaseB && !loopIn.indexIn;
  property p_irq; hostIrq == |(statusByte[6:1] & intMask); endproperty
  a_irq: assert property (p_irq) else $error("irq not flags and mask");
  property p_rstw; clearLoop |-> motorOut == ZERO_WIDE; endproperty
  a_rstw: assert property (p_rstw) else $error("reset port not wide zero");
  property p_rstb; clearLoop |-> statusByte[BIT_BUSY]; endproperty
  a_rstb: assert property (p_rstb) else $error("not busy in reset");
  property p_rend;
    $fell(clearLoop) |-> ##[0:1] (motorOut == ZERO_NARROW && !wideMode && intMask == MASK_RESET);
  endproperty
  a_rend: assert property (p_rend) else $error("reset end defaults");
  property p_busy; $rose(statusByte[BIT_BUSY]) |-> statusByte[BIT_BUSY][*8]; endproperty
  a_busy: assert property (p_busy) else $error("busy too short");
  property p_narrow;
    $rose(hostWr.wrStrobe) && cmdTake && hostWr.data == CMD_NARROW |-> ##[1:20] !wideMode;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow not selected");
  property p_home;
    $rose(hostWr.wrStrobe) && cmdTake && hostWr.data == CMD_DEF_HOME |-> ##[1:20] startHold;
  endproperty
  a_home: assert property (p_home) else $error("home hold missing");
  property p_index; $changed(indexPos) && !clearLoop |-> $past(idxLow); endproperty
  a_index: assert property (p_index) else $error("index capture not at low");
  c_rend: cover property ($fell(clearLoop));
  c_irq: cover property (hostIrq);
  c_idx: cover property ($rose(statusByte[BIT_INDEX]));
endmodule

bind mcmd_core mcmd_core_sva u_sva (.clk_sys, .rst_n, .hostWr, .loopIn, .condIn, .statusByte,
  .hostIrq, .motorOut, .wideMode, .clearLoop, .startHold, .homeOffset, .indexPos, .intMask);

// >>> testbench/mcmd_host_model.sv
`timescale 1ns/1ps
module mcmd_host_model
  import mcmd_pkg::*;
(
  input  wire logic       clk_sys,    // Clock
  input  wire logic [7:0] statusByte, // Status from device
  output mcmd_hostwr_t    hostWr      // Write port
);
  initial hostWr = '{portSelN: 1'b1, wrStrobe: 1'b0, data: 8'hA5};
  task automatic put(input logic sel, input logic [7:0] b);
    @(negedge clk_sys);
    hostWr.portSelN = sel;
    hostWr.data     = b;
    hostWr.wrStrobe = 1'b1;
    @(negedge clk_sys);
    hostWr.wrStrobe = 1'b0;
    @(negedge clk_sys);
    hostWr.data = ~b;  // Released bus shows no stale byte
  endtask
  task automatic wait_idle;
    int n = 0;
    while (statusByte[BIT_BUSY] !== 1'b0 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  task automatic cmd(input logic [7:0] b);
    wait_idle();
    put(1'b0, b);
  endtask
  task automatic word(input logic [15:0] w);
    wait_idle();
    put(1'b1, w[15:8]);
    put(1'b1, w[7:0]);
  endtask
endmodule

// >>> testbench/mcmd_core_tb.sv
`timescale 1ns/1ps
module mcmd_core_tb
  import mcmd_pkg::*;
;
  logic               clk_sys, rst_n, hostIrq, wideMode, clearLoop, startHold;
  mcmd_hostwr_t       hostWr;
  mcmd_loop_t         loopIn;
  logic [6:1]         condIn, intMask;
  logic [7:0]         statusByte;
  logic [11:0]        motorOut;
  logic signed [31:0] homeOffset, indexPos;
  int                 error_cnt = 0, check_count = 0, cyc = 0;
  mcmd_core DUT (.clk_sys, .rst_n, .hostWr, .loopIn, .condIn, .statusByte, .hostIrq,
    .motorOut, .wideMode, .clearLoop, .startHold, .homeOffset, .indexPos, .intMask);
  mcmd_host_model HM (.clk_sys, .statusByte, .hostWr);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic summarize;
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic t_reset;
    cyc_n(1);
    chk("clearLoop", 32'h1, clearLoop);
    chk("motorOut", ZERO_WIDE, motorOut);
    chk("busy", 32'h1, statusByte[BIT_BUSY]);
    cyc_n(RESET_CYC + 10);
    chk("motorOut", ZERO_NARROW, motorOut);
    chk("wideMode", 32'h0, wideMode);
    chk("intMask", MASK_RESET, intMask);
    chk("homeOffset", 32'h0, homeOffset);
  endtask
  task automatic t_width;
    HM.cmd(CMD_WIDE);
    HM.wait_idle();
    chk("wideMode", 32'h1, wideMode);
    chk("motorOut", ZERO_WIDE, motorOut);
    HM.cmd(CMD_NARROW);
    HM.wait_idle();
    chk("wideMode", 32'h0, wideMode);
  endtask
  task automatic t_busy;
    HM.cmd(CMD_ARM_INDEX);
    HM.put(1'b0, CMD_WIDE);
    HM.wait_idle();
    chk("wideMode", 32'h0, wideMode);
  endtask
  task automatic t_irq;
    HM.cmd(CMD_MASK);
    HM.word(16'h0040);
    HM.wait_idle();
    chk("intMask", 32'h20, intMask);
    condIn = 6'h0B;
    cyc_n(1);
    condIn = 6'h00;
    cyc_n(2);
    chk("condFlags", 32'h0B, statusByte[6:1]);
    chk("hostIrq", 32'h0, hostIrq);
    HM.cmd(CMD_BP_ABS);
    HM.word(16'h0000);
    HM.word(16'h0010);
    HM.wait_idle();
    loopIn.actualPos = 32'sh10;
    cyc_n(3);
    chk("bkptEarly", 32'h0, statusByte[BIT_BKPT]);
    loopIn.sampleTick = 1'b1;
    cyc_n(1);
    loopIn.sampleTick = 1'b0;
    cyc_n(2);
    chk("bkptFlag", 32'h1, statusByte[BIT_BKPT]);
    chk("hostIrq", 32'h1, hostIrq);
    HM.cmd(CMD_FLAG_CLR);
    HM.word(16'h00BF);
    HM.wait_idle();
    chk("flagsClr", 32'h0B, statusByte[6:1]);
    chk("hostIrq", 32'h0, hostIrq);
  endtask
  task automatic t_perr;
    loopIn.filterOut = 12'hC00;
    HM.cmd(CMD_ERR_REPORT);
    HM.word(16'h0010);
    HM.wait_idle();
    loopIn.posError = 16'shFFEF;
    cyc_n(3);
    chk("perrReport", 32'h1, statusByte[BIT_PERR]);
    chk("motorOut", 32'h0C0, motorOut);
    loopIn.posError = 16'sh0000;
    HM.cmd(CMD_FLAG_CLR);
    HM.word(16'h00DF);
    HM.wait_idle();
    chk("perrClr", 32'h0, statusByte[BIT_PERR]);
    HM.cmd(CMD_ERR_STOP);
    HM.word(16'h0010);
    HM.wait_idle();
    loopIn.posError = 16'sh0010;
    cyc_n(3);
    chk("perrFlag", 32'h0, statusByte[BIT_PERR]);
    chk("motorOut", 32'h0C0, motorOut);
    loopIn.posError = 16'shFFEF;
    cyc_n(3);
    chk("perrFlag", 32'h1, statusByte[BIT_PERR]);
    chk("motorOut", ZERO_NARROW, motorOut);
    loopIn.posError = 16'sh0000;
  endtask
  task automatic t_index;
    loopIn.actualPos = 32'sh55;
    loopIn.indexIn = 1'b0;
    cyc_n(3);
    chk("idxEarly", 32'h0, statusByte[BIT_INDEX]);
    loopIn.phaseA = 1'b0;
    loopIn.phaseB = 1'b0;
    cyc_n(3);
    chk("idxFlag", 32'h1, statusByte[BIT_INDEX]);
    chk("indexPos", 32'h55, indexPos);
  endtask
  task automatic t_home;
    loopIn.actualPos = 32'sh100;
    HM.cmd(CMD_DEF_HOME);
    HM.wait_idle();
    chk("homeOffset", 32'h100, homeOffset);
    chk("startHold", 32'h1, startHold);
    HM.cmd(CMD_START);
    HM.wait_idle();
    chk("startHold", 32'h0, startHold);
  endtask
  task automatic pulse_tick;
    loopIn.sampleTick = 1'b1;
    cyc_n(1);
    loopIn.sampleTick = 1'b0;
    cyc_n(2);
  endtask
  task automatic t_bprel;
    loopIn.targetPos = 32'sh300;
    HM.cmd(CMD_BP_REL);
    HM.word(16'h0000);
    HM.word(16'h0040);
    HM.wait_idle();
    loopIn.actualPos = 32'sh33F;
    pulse_tick();
    chk("bkptRelEarly", 32'h0, statusByte[BIT_BKPT]);
    loopIn.actualPos = 32'sh340;
    pulse_tick();
    chk("bkptRel", 32'h1, statusByte[BIT_BKPT]);
    chk("hostIrq", 32'h1, hostIrq);
  endtask
  task automatic t_cmdreset;
    loopIn.actualPos = 32'sh200;
    loopIn.filterOut = ZERO_WIDE;
    HM.cmd(CMD_WIDE);
    HM.wait_idle();
    HM.cmd(CMD_RESET);
    cyc_n(4);
    chk("clearLoop", 32'h1, clearLoop);
    chk("motorOut", ZERO_WIDE, motorOut);
    cyc_n(RESET_CYC + 10);
    chk("homeOffset", 32'h200, homeOffset);
    chk("wideMode", 32'h0, wideMode);
    chk("intMask", MASK_RESET, intMask);
    chk("flags", 32'h0, statusByte[6:1]);
    chk("motorOut", ZERO_NARROW, motorOut);
    HM.cmd(CMD_WIDE);
    HM.wait_idle();
    chk("wideMode", 32'h1, wideMode);
  endtask
  initial begin
    rst_n = 1'b0;
    condIn = 6'h00;
    loopIn = '0;
    loopIn.filterOut = ZERO_WIDE;
    {loopIn.phaseA, loopIn.phaseB, loopIn.indexIn} = 3'h7;
    cyc_n(3);
    rst_n = 1'b1;
    t_reset();
    t_width();
    t_busy();
    t_irq();
    t_perr();
    t_index();
    t_home();
    t_bprel();
    t_cmdreset();
    summarize();
  end
endmodule
